// File: mdg_pkg.sv
package mdg_pkg;
   // I/O range codes on address bits 15..12
   localparam logic [3:0] IO_EXT   = 4'h8;
   localparam logic [3:0] IO_MODEM = 4'h9;
   localparam logic [3:0] IO_PIO   = 4'hb;
   localparam logic [3:0] IO_UDATA = 4'hc;
   localparam logic [3:0] IO_UMODE = 4'hd;
   localparam logic [3:0] IO_LATCH = 4'he;
   localparam logic [3:0] IO_LCD   = 4'hf;
   // Parallel I/O and timer registers, and the system latch port
   localparam logic [7:0] PIO_COMMAND_STATUS = 8'hb0;
   localparam logic [7:0] PIO_PORT_A_DATA    = 8'hb1;
   localparam logic [7:0] PIO_PORT_B_DATA    = 8'hb2;
   localparam logic [7:0] PIO_PORT_C_DATA    = 8'hb3;
   localparam logic [7:0] TIMER_COUNT_LOW    = 8'hb4;
   localparam logic [7:0] TIMER_COUNT_HIGH   = 8'hb5;
   localparam logic [7:0] SYS_LATCH_PORT     = 8'he0;
   // System output latch bits
   localparam int LAT_BANK  = 0;
   localparam int LAT_PRINTER_STROBE_N  = 1;
   localparam int LAT_CLK   = 2;
   localparam int LAT_MOTOR = 3;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   // Port bits
   localparam int PB_KEY8   = 0;
   localparam int PB_GATE   = 2;
   localparam int PB_TOGGLE = 5;
   localparam int PC_ONLINE = 1;
   localparam int PC_BUSY   = 2;
   localparam int PC_BAR    = 3;
   localparam int ST_TDONE  = 6;
   // Timer command and mode codes
   localparam logic [1:0] TCMD_START   = 2'b11;
   localparam logic [1:0] TCMD_STOP    = 2'b01;
   localparam logic [1:0] TMODE_SQUARE = 2'b01;
   localparam logic [7:0] TONE_START   = 8'hc0;
   // Controller registers on APB
   localparam logic [7:0] HST_CMD    = 8'h00;
   localparam logic [7:0] HST_ADDR   = 8'h04;
   localparam logic [7:0] HST_DATA   = 8'h08;
   localparam logic [7:0] HST_STATUS = 8'h0c;
   localparam logic [7:0] HST_SERIAL = 8'h10;

   typedef enum logic [2:0] {
      C_NONE, C_IO_WR, C_IO_RD, C_MEM_WR, C_MEM_RD, C_PRINT, C_TONE
   } mdg_cmd_t;
endpackage : mdg_pkg

// File: mdg_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mdg_bus_if;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        io_m;
   logic        rd;
   logic        wr;
   logic [7:0]  rdata;
   logic        rd_valid;
   logic        barcode_irq;
   logic        cpu_serial_in;
   logic        cpu_serial_out;

   modport cpu (output addr, wdata, io_m, rd, wr, cpu_serial_out,
                input rdata, rd_valid, barcode_irq, cpu_serial_in);
   modport glue (input addr, wdata, io_m, rd, wr, cpu_serial_out,
                 output rdata, rd_valid, barcode_irq, cpu_serial_in);
endinterface : mdg_bus_if
`default_nettype wire

// File: mdg_glue.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A15 splits ROM and RAM halves
// - A14..A13 pick one of four RAMs
// - Bank bit picks standard or optional ROM
// - Bank bit latched from data bit 0
// - A15..A12 decode seven I/O selects
// - Low I/O free; 80-8F external controller
// - 90-9F modem relay; B0-BF parallel chip
// - C0-CF UART data; D0-DF UART mode
// - E0-EF latch and keys; F0-FF LCD
// - Low bits pick parallel chip registers
// - Port A plus B0 strobe keys; rows readable
// - Latch bit 3 drives cassette motor
// - Print only when not busy, then strobe
// - Printer holds busy until character printed
// - Offline printer blocks print data
// - Inverted wand feeds port and interrupt
// - Gate high: buzzer follows toggle bit
// - Timer square wave drives buzzer tone
// - Cassette write inverted; read to serial in
// - Latch bit 2 strobes clock chip
module mdg_glue
   import mdg_pkg::*;
#(
   parameter int TIMER_W = 14
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  reset,
   // CPU bus
   mdg_bus_if.glue    bus,
   // Memory selects
   output logic       rom_std_sel_n,
   output logic       rom_opt_sel_n,
   output logic [3:0] ram_sel_n,
   // I/O selects
   output logic       ext_io_ctrl_sel_n,
   output logic       modem_relay_sel_n,
   output logic       pio_chip_sel_n,
   output logic       uart_data_sel_n,
   output logic       uart_mode_sel_n,
   output logic       sys_latch_sel_n,
   output logic       lcd_sel_n,
   // Latch outputs
   output logic       rom_bank_select,
   output logic       printer_strobe_n,
   output logic       clock_chip_strobe,
   output logic       tape_motor_drive,
   // Keyboard
   output logic [8:0] key_strobe,
   input  wire logic [7:0] key_rows,
   // Printer
   output logic [7:0] printer_data,
   input  wire logic  printer_busy_in,
   input  wire logic  printer_online_in,
   // Bar code, cassette, buzzer
   input  wire logic  barcode_wand,
   input  wire logic  cassette_read_in,
   output logic       cassette_write,
   output logic       buzzer_drive,
   output logic       timer_out
);
   if (TIMER_W != 14) begin : g_chk
      $error("mdg_glue: TIMER_W must be 14");
   end

   typedef struct packed {
      logic [3:0]         lat;
      logic [7:0]         pa;
      logic [7:0]         pb;
      logic [7:0]         cmd;
      logic [7:0]         tlo;
      logic [7:0]         thi;
      logic               trun;
      logic               tdone;
      logic               tout;
      logic [TIMER_W-1:0] tcnt;
      logic [1:0]         busy_s;
      logic [1:0]         onl_s;
      logic               wand_s1;
      logic               bar;
      logic [1:0]         cas_s;
      logic [7:0]         rows_s1;
      logic [7:0]         rows_s2;
      logic               rom_std_n;
      logic               rom_opt_n;
      logic [3:0]         ram_n;
      logic [7:0]         io_n;
      logic [7:0]         rdata;
      logic               rd_valid;
      logic               cas_wr;
      logic               buzz;
   } mdg_glue_st_t;

   mdg_glue_st_t s;
   mdg_glue_st_t next_s;

   function automatic logic io_hit(input logic [15:0] a, input logic [3:0] r);
      return a[15:12] == r;
   endfunction : io_hit

   logic               acc;
   logic               io_wr;
   logic               io_rd;
   logic [TIMER_W-1:0] half;

   always_comb begin
      next_s   = s;
      acc      = bus.rd | bus.wr;
      io_wr    = bus.wr & bus.io_m;
      io_rd    = bus.rd & bus.io_m;
      half     = {s.thi[5:0], s.tlo} >> 1;
      if (half == '0) begin
         half = TIMER_W'(1);
      end
      // Pin synchronisers
      next_s.busy_s  = {s.busy_s[0], printer_busy_in};
      next_s.onl_s   = {s.onl_s[0], printer_online_in};
      next_s.wand_s1 = barcode_wand;
      next_s.bar     = ~s.wand_s1;
      next_s.cas_s   = {s.cas_s[0], cassette_read_in};
      next_s.rows_s1 = key_rows;
      next_s.rows_s2 = s.rows_s1;
      next_s.cas_wr  = ~bus.cpu_serial_out;
      next_s.rom_std_n = 1'b1;
      next_s.rom_opt_n = 1'b1;
      next_s.ram_n     = 4'hf;
      if (acc && !bus.io_m) begin
         if (!bus.addr[15]) begin
            next_s.rom_std_n = s.lat[LAT_BANK];
            next_s.rom_opt_n = ~s.lat[LAT_BANK];
         end else begin
            next_s.ram_n[bus.addr[14:13]] = 1'b0;
         end
      end
      next_s.io_n = 8'hff;
      if (acc && bus.io_m && bus.addr[15]) begin
         next_s.io_n[bus.addr[14:12]] = 1'b0;
      end
      if (io_wr && io_hit(bus.addr, IO_LATCH)) begin
         next_s.lat = bus.wdata[3:0];
      end
      if (io_wr && io_hit(bus.addr, IO_PIO)) begin
         case (bus.addr[10:8])
            PIO_COMMAND_STATUS[2:0]: begin
               next_s.cmd = bus.wdata;
               if (bus.wdata[7:6] == TCMD_START) begin
                  next_s.trun = 1'b1;
                  next_s.tcnt = half;
                  next_s.tout = 1'b1;
               end else if (bus.wdata[7:6] == TCMD_STOP) begin
                  next_s.trun = 1'b0;
               end
            end
            PIO_PORT_A_DATA[2:0]:  next_s.pa  = bus.wdata;
            PIO_PORT_B_DATA[2:0]:  next_s.pb  = bus.wdata;
            TIMER_COUNT_LOW[2:0]:  next_s.tlo = bus.wdata;
            TIMER_COUNT_HIGH[2:0]: next_s.thi = bus.wdata;
            default: ;
         endcase
      end
      // Read answer one cycle after the strobe
      next_s.rd_valid = bus.rd;
      next_s.rdata    = 8'h00;
      if (io_rd && io_hit(bus.addr, IO_PIO)) begin
         case (bus.addr[10:8])
            PIO_COMMAND_STATUS[2:0]: begin
               next_s.rdata[ST_TDONE] = s.tdone;
               next_s.tdone = 1'b0;
            end
            PIO_PORT_A_DATA[2:0]:  next_s.rdata = s.pa;
            PIO_PORT_B_DATA[2:0]:  next_s.rdata = s.pb;
            PIO_PORT_C_DATA[2:0]: begin
               next_s.rdata[PC_ONLINE] = s.onl_s[1];
               next_s.rdata[PC_BUSY]   = s.busy_s[1];
               next_s.rdata[PC_BAR]    = s.bar;
            end
            TIMER_COUNT_LOW[2:0]:  next_s.rdata = s.tlo;
            TIMER_COUNT_HIGH[2:0]: next_s.rdata = s.thi;
            default: ;
         endcase
      end
      if (io_rd && io_hit(bus.addr, IO_LATCH)) begin
         next_s.rdata = s.rows_s2;
      end
      if (s.trun) begin
         if (s.tcnt <= TIMER_W'(1)) begin
            next_s.tcnt = half;
            if (s.thi[7:6] == TMODE_SQUARE) begin
               next_s.tout = ~s.tout;
            end else begin
               next_s.tout  = 1'b0;
               next_s.trun  = 1'b0;
               next_s.tdone = 1'b1;
            end
         end else begin
            next_s.tcnt = s.tcnt - TIMER_W'(1);
         end
      end
      next_s.buzz = s.pb[PB_GATE] & (s.pb[PB_TOGGLE] | s.tout);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s       <= '0;
         s.lat   <= LATCH_RESET;
         s.rom_std_n <= 1'b1;
         s.rom_opt_n <= 1'b1;
         s.ram_n <= 4'hf;
         s.io_n  <= 8'hff;
         s.cas_wr <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rom_std_sel_n     = s.rom_std_n;
   assign rom_opt_sel_n     = s.rom_opt_n;
   assign ram_sel_n         = s.ram_n;
   assign ext_io_ctrl_sel_n = s.io_n[0];
   assign modem_relay_sel_n = s.io_n[1];
   assign pio_chip_sel_n    = s.io_n[3];
   assign uart_data_sel_n   = s.io_n[4];
   assign uart_mode_sel_n   = s.io_n[5];
   assign sys_latch_sel_n   = s.io_n[6];
   assign lcd_sel_n         = s.io_n[7];
   assign rom_bank_select   = s.lat[LAT_BANK];
   assign printer_strobe_n  = ~s.lat[LAT_PRINTER_STROBE_N];
   assign clock_chip_strobe = s.lat[LAT_CLK];
   assign tape_motor_drive  = s.lat[LAT_MOTOR];
   assign key_strobe        = {s.pb[PB_KEY8], s.pa};
   assign printer_data      = s.pa;
   assign cassette_write    = s.cas_wr;
   assign buzzer_drive      = s.buzz;
   assign timer_out         = s.tout;
   assign bus.rdata         = s.rdata;
   assign bus.rd_valid      = s.rd_valid;
   assign bus.barcode_irq   = s.bar;
   assign bus.cpu_serial_in = s.cas_s[1];
endmodule : mdg_glue
`default_nettype wire

// File: mdg_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module mdg_cpu
   import mdg_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // CPU bus
   mdg_bus_if.cpu           bus
);
   typedef enum {H_IDLE, H_ISSUE, H_WAIT} mdg_hst_t;

   typedef struct packed {
      logic        io;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } mdg_op_t;

   typedef struct packed {
      mdg_hst_t    st;
      mdg_cmd_t    cmd;
      logic [1:0]  step;
      logic [15:0] addr;
      logic [15:0] data;
      logic [7:0]  shadow;
      logic [7:0]  rdata;
      logic        refused;
      logic        serial;
      logic        b_rd;
      logic        b_wr;
      logic        b_io;
      logic [15:0] b_addr;
      logic [7:0]  b_wdata;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } mdg_cpu_st_t;

   mdg_cpu_st_t s;
   mdg_cpu_st_t next_s;

   function automatic logic [15:0] port(input logic [7:0] p);
      return {p, p};
   endfunction : port

   function automatic mdg_op_t op_of(input mdg_cmd_t c, input logic [1:0] k,
                                     input logic [15:0] a, input logic [15:0] d,
                                     input logic [7:0] sh);
      mdg_op_t o;
      o = '{io: 1'b1, wr: 1'b1, addr: a, data: d[7:0]};
      case (c)
         C_PRINT: begin
            case (k)
               2'd0: o = '{1'b1, 1'b0, port(PIO_PORT_C_DATA), 8'h00};
               2'd1: o = '{1'b1, 1'b1, port(PIO_PORT_A_DATA), d[7:0]};
               2'd2: o = '{1'b1, 1'b1, port(SYS_LATCH_PORT), sh | 8'h02};
               default: o = '{1'b1, 1'b1, port(SYS_LATCH_PORT), sh & 8'hfd};
            endcase
         end
         C_TONE: begin
            case (k)
               2'd0: o = '{1'b1, 1'b1, port(TIMER_COUNT_LOW), d[7:0]};
               2'd1: o = '{1'b1, 1'b1, port(TIMER_COUNT_HIGH), d[15:8]};
               default: o = '{1'b1, 1'b1, port(PIO_COMMAND_STATUS), TONE_START};
            endcase
         end
         C_IO_RD:  o.wr = 1'b0;
         C_MEM_WR: o.io = 1'b0;
         C_MEM_RD: o = '{1'b0, 1'b0, a, 8'h00};
         default: ;
      endcase
      return o;
   endfunction : op_of

   function automatic logic [1:0] last_of(input mdg_cmd_t c);
      return (c == C_PRINT) ? 2'd3 : (c == C_TONE) ? 2'd2 : 2'd0;
   endfunction : last_of

   mdg_op_t op;
   logic    wr_go;

   always_comb begin
      next_s         = s;
      op             = op_of(s.cmd, s.step, s.addr, s.data, s.shadow);
      wr_go          = psel & penable & s.pready & pwrite;
      next_s.b_rd    = 1'b0;
      next_s.b_wr    = 1'b0;
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      // APB answer one wait state after setup
      if (psel && penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = 32'h0;
         case (paddr)
            HST_CMD:    next_s.prdata = {29'h0, s.cmd};
            HST_ADDR:   next_s.prdata = {16'h0, s.addr};
            HST_DATA:   next_s.prdata = {16'h0, s.data};
            HST_STATUS: next_s.prdata = {16'h0, s.rdata, 4'h0, bus.cpu_serial_in,
                                         bus.barcode_irq, s.refused,
                                         s.st != H_IDLE};
            HST_SERIAL: next_s.prdata = {31'h0, s.serial};
            default:    next_s.pslverr = 1'b1;
         endcase
      end
      if (wr_go) begin
         case (paddr)
            HST_ADDR:   next_s.addr   = pwdata[15:0];
            HST_DATA:   next_s.data   = pwdata[15:0];
            HST_SERIAL: next_s.serial = pwdata[0];
            HST_CMD: begin
               if (s.st == H_IDLE && pwdata[2:0] != 3'(C_NONE)) begin
                  next_s.cmd     = mdg_cmd_t'(pwdata[2:0]);
                  next_s.step    = 2'd0;
                  next_s.refused = 1'b0;
                  next_s.st      = H_ISSUE;
               end
            end
            default: ;
         endcase
      end
      case (s.st)
         H_IDLE: ;
         H_ISSUE: begin
            next_s.b_io    = op.io;
            next_s.b_addr  = op.addr;
            next_s.b_wdata = op.data;
            next_s.b_rd    = ~op.wr;
            next_s.b_wr    = op.wr;
            if (op.wr && op.io && op.addr[15:12] == IO_LATCH) begin
               next_s.shadow = op.data;
            end
            if (!op.wr) begin
               next_s.st = H_WAIT;
            end else if (s.step == last_of(s.cmd)) begin
               next_s.st = H_IDLE;
            end else begin
               next_s.step = s.step + 2'd1;
            end
         end
         H_WAIT: begin
            if (bus.rd_valid) begin
               next_s.rdata = bus.rdata;
               next_s.st    = H_IDLE;
               if (s.cmd == C_PRINT) begin
                  if (!bus.rdata[PC_ONLINE]) begin
                     next_s.refused = 1'b1;
                  end else if (bus.rdata[PC_BUSY]) begin
                     next_s.st = H_ISSUE;
                  end else begin
                     next_s.step = 2'd1;
                     next_s.st   = H_ISSUE;
                  end
               end
            end
         end
         default: next_s.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s    <= '0;
         s.st <= H_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign bus.addr           = s.b_addr;
   assign bus.wdata          = s.b_wdata;
   assign bus.io_m           = s.b_io;
   assign bus.rd             = s.b_rd;
   assign bus.wr             = s.b_wr;
   assign bus.cpu_serial_out = s.serial;
   assign prdata             = s.prdata;
   assign pready             = s.pready;
   assign pslverr            = s.pslverr;
endmodule : mdg_cpu
`default_nettype wire

// File: mdg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mdg_chk
   import mdg_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        io_m,
   input wire logic        rd,
   input wire logic        wr,
   input wire logic        barcode_irq,
   input wire logic        cpu_serial_in,
   input wire logic        cpu_serial_out,
   // Glue pins
   input wire logic        rom_std_sel_n,
   input wire logic        rom_opt_sel_n,
   input wire logic [3:0]  ram_sel_n,
   input wire logic        ext_io_ctrl_sel_n,
   input wire logic        pio_chip_sel_n,
   input wire logic        sys_latch_sel_n,
   input wire logic        rom_bank_select,
   input wire logic        printer_strobe_n,
   input wire logic        clock_chip_strobe,
   input wire logic        tape_motor_drive,
   input wire logic        barcode_wand,
   input wire logic        cassette_read_in,
   input wire logic        cassette_write
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic       mem_s;
   logic       io_s;
   logic       lat_w;
   logic [3:0] lat;
   logic [2:0] since;
   assign mem_s = !io_m && (rd || wr);
   assign io_s  = io_m && (rd || wr);
   assign lat_w = io_m && wr && addr[15:12] == IO_LATCH;
   assign lat   = {tape_motor_drive, clock_chip_strobe, !printer_strobe_n, rom_bank_select};
   // Cycles since reset, saturating
   always_ff @(posedge clk) begin
      if (reset) since <= 3'h0;
      else if (since != 3'h7) since <= since + 3'h1;
   end
   mem_half_a: assert property (mem_s |=> (&ram_sel_n) == !$past(addr[15])
      && (rom_std_sel_n && rom_opt_sel_n) == $past(addr[15])) else $error("memory half wrong");
   ram_pick_a: assert property (mem_s && addr[15] |=>
      ram_sel_n == ~(4'h1 << $past(addr[14:13]))) else $error("ram select wrong");
   bank_pick_a: assert property (mem_s && !addr[15] |=>
      rom_std_sel_n == rom_bank_select && rom_opt_sel_n == !rom_bank_select)
      else $error("rom bank wrong");
   latch_load_a: assert property (lat_w |=>
      lat == $past(wdata[3:0])) else $error("latch load wrong");
   latch_hold_a: assert property (!lat_w |=> $stable(lat)) else $error("latch moved");
   pio_sel_a: assert property (io_s && addr[15:12] == IO_PIO |=>
      !pio_chip_sel_n && sys_latch_sel_n) else $error("pio select wrong");
   latch_sel_a: assert property (io_s && addr[15:12] == IO_LATCH |=>
      !sys_latch_sel_n && pio_chip_sel_n) else $error("latch select wrong");
   io_free_a: assert property (io_s && !addr[15] |=>
      ext_io_ctrl_sel_n && pio_chip_sel_n && sys_latch_sel_n) else $error("low io selected");
   sel_cause_a: assert property (!pio_chip_sel_n |->
      $past(io_s) && $past(addr[15:12]) == IO_PIO) else $error("stray pio select");
   reset_clear_a: assert property ($past(reset) |-> lat == 4'h0)
      else $error("latch not cleared");
   wand_sync_a: assert property (since > 3'h4 && $stable(barcode_wand)
      && $past(barcode_wand, 2) == barcode_wand && $past(barcode_wand, 3) == barcode_wand
      |-> barcode_irq == !barcode_wand) else $error("wand level wrong");
   tape_read_a: assert property (since > 3'h4 && $stable(cassette_read_in)
      && $past(cassette_read_in, 2) == cassette_read_in
      && $past(cassette_read_in, 3) == cassette_read_in
      |-> cpu_serial_in == cassette_read_in) else $error("tape read wrong");
   tape_write_a: assert property (!$past(reset) |->
      cassette_write == !$past(cpu_serial_out)) else $error("tape write wrong");
   cover property (lat_w && wdata[1]);
   cover property (mem_s && addr[15] && addr[14:13] == 2'h3);
   cover property (io_s && addr[15:12] == IO_PIO);
endmodule : mdg_chk
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import mdg_pkg::*;
   ;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, key_rows, printer_data;
   logic [31:0] pwdata, prdata, q, d;
   logic        printer_busy_in, printer_online_in, barcode_wand, cassette_read_in;
   logic        rom_std_sel_n, rom_opt_sel_n, ext_io_ctrl_sel_n, modem_relay_sel_n;
   logic        pio_chip_sel_n, uart_data_sel_n, uart_mode_sel_n, sys_latch_sel_n;
   logic        lcd_sel_n, rom_bank_select, printer_strobe_n, clock_chip_strobe;
   logic        tape_motor_drive, cassette_write, buzzer_drive, timer_out, ps, pt, pb, b, io;
   logic [3:0]  ram_sel_n;
   logic [8:0]  key_strobe;
   logic [12:0] seen;
   logic [15:0] a;
   integer      seed;
   int          n_fail, tests_run, i, s0, t0;
   int          n_stb = 0;
   int          n_tick = 0;
   int          n_buz = 0;
   mdg_bus_if   bus ();
   wire logic [12:0] sels = {rom_std_sel_n, rom_opt_sel_n, ram_sel_n, ext_io_ctrl_sel_n,
      modem_relay_sel_n, pio_chip_sel_n, uart_data_sel_n, uart_mode_sel_n, sys_latch_sel_n,
      lcd_sel_n};
   mdg_cpu mdg_cpu_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .bus);
   mdg_glue #(.TIMER_W(14)) mdg_glue_i (.clk, .reset, .bus, .rom_std_sel_n, .rom_opt_sel_n,
      .ram_sel_n, .ext_io_ctrl_sel_n, .modem_relay_sel_n, .pio_chip_sel_n, .uart_data_sel_n,
      .uart_mode_sel_n, .sys_latch_sel_n, .lcd_sel_n, .rom_bank_select, .printer_strobe_n,
      .clock_chip_strobe, .tape_motor_drive, .key_strobe, .key_rows, .printer_data,
      .printer_busy_in, .printer_online_in, .barcode_wand, .cassette_read_in,
      .cassette_write, .buzzer_drive, .timer_out);
   mdg_chk mdg_chk_i (.clk, .reset, .addr(bus.addr), .wdata(bus.wdata), .io_m(bus.io_m),
      .rd(bus.rd), .wr(bus.wr), .barcode_irq(bus.barcode_irq),
      .cpu_serial_in(bus.cpu_serial_in), .cpu_serial_out(bus.cpu_serial_out),
      .rom_std_sel_n, .rom_opt_sel_n, .ram_sel_n, .ext_io_ctrl_sel_n, .pio_chip_sel_n,
      .sys_latch_sel_n, .rom_bank_select, .printer_strobe_n, .clock_chip_strobe,
      .tape_motor_drive, .barcode_wand, .cassette_read_in, .cassette_write);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Catch select pulses, count strobe falling edges and timer and buzzer rising edges
   always @(posedge clk) begin
      if (sels !== 13'h1fff) seen <= sels;
      ps <= printer_strobe_n;
      pt <= timer_out;
      pb <= buzzer_drive;
      if (ps && !printer_strobe_n) n_stb++;
      if (!pt && timer_out) n_tick++;
      if (!pb && buzzer_drive) n_buz++;
   end
   function automatic logic [12:0] exp_sel(input logic io_, input logic [15:0] ad,
                                           input logic bk);
      logic [12:0] e;
      e = 13'h1fff;
      if (!io_ && !ad[15]) e[12 - bk] = 1'b0;
      else if (!io_) e[7 + ad[14:13]] = 1'b0;
      else if (ad[15:12] == 4'h8) e[6] = 1'b0;
      else if (ad[15:12] == 4'h9) e[5] = 1'b0;
      else if (ad[15:12] > 4'ha) e[4'hf - ad[15:12]] = 1'b0;
      return e;
   endfunction : exp_sel
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize(input int extra);
      n_fail += extra;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dv);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= dv;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) summarize(1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, HST_STATUS, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 60);
      if (n >= 60) summarize(1);
   endtask : wait_idle
   task automatic op(input mdg_cmd_t c, input logic [15:0] ad, input logic [15:0] dv);
      apb(1'b1, HST_ADDR, 32'(ad));
      apb(1'b1, HST_DATA, 32'(dv));
      apb(1'b1, HST_CMD, 32'(c));
      wait_idle();
   endtask : op
   initial begin
      seed = 32'h8d9c6ba4;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, key_rows} = '0;
      {printer_busy_in, barcode_wand, cassette_read_in} = '0;
      printer_online_in = 1'b1;
      n_fail = 0;
      tests_run = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check(32'({rom_bank_select, printer_strobe_n, clock_chip_strobe, tape_motor_drive}),
            32'h4);
      apb(1'b0, 8'h3c, 32'h0);
      check(32'(err), 32'h1);
      for (i = 0; i < 6; i++) begin
         d = $random(seed);
         if (i == 0) d[3:0] = 4'hf;
         op(C_IO_WR, {2{4'he, d[7:4]}}, 16'(d[7:0]));
         check(32'({tape_motor_drive, clock_chip_strobe, !printer_strobe_n, rom_bank_select}),
               32'(d[3:0]));
      end
      for (i = 0; i < 48; i++) begin
         d = $random(seed);
         if (i % 16 == 0) begin
            b = d[31];
            op(C_IO_WR, 16'he0e0, 16'(b));
         end
         io = (i < 16);
         a = io ? {2{i[3:0], d[3:0]}} : d[15:0];
         if (i == 17) a = 16'h7fff;
         if (i == 33) a = 16'h8000;
         seen <= '1;
         op(io ? C_IO_RD : (d[16] ? C_MEM_WR : C_MEM_RD), a, d[31:16]);
         check(32'(seen), 32'(exp_sel(io, a, b)));
      end
      d = $random(seed);
      op(C_IO_WR, 16'hb9b9, 16'(d[7:0]));
      op(C_IO_WR, 16'hb2b2, 16'(d[15:8]));
      check(32'(key_strobe), 32'({d[8], d[7:0]}));
      op(C_IO_RD, 16'hb1b1, 16'h0);
      check(32'(q[15:8]), 32'(d[7:0]));
      key_rows <= d[23:16];
      op(C_IO_RD, 16'he5e5, 16'h0);
      check(32'(q[15:8]), 32'(d[23:16]));
      for (i = 0; i < 4; i++) begin
         op(C_IO_WR, 16'hb2b2, {10'h0, i[1], 2'b0, i[0], 2'b0});
         check(32'({timer_out, buzzer_drive}), 32'(i[0] & i[1]));
      end
      op(C_IO_WR, 16'hb2b2, 16'h0004);
      op(C_TONE, 16'h0, 16'h4010);
      t0 = n_tick;
      s0 = n_buz;
      repeat (160) @(posedge clk);
      check(32'((n_tick - t0) inside {[9:11]}), 32'h1);
      check(32'((n_buz - s0) inside {[9:11]}), 32'h1);
      // One-shot timer run through mirrored ports
      op(C_IO_WR, 16'hbdbd, 16'h0000);
      op(C_IO_WR, 16'hb0b0, 16'(TONE_START));
      repeat (20) @(posedge clk);
      op(C_IO_RD, 16'hb8b8, 16'h0);
      check(32'({timer_out, q[14]}), 32'h1);
      printer_busy_in <= 1'b1;
      s0 = n_stb;
      apb(1'b1, HST_DATA, 32'h5a);
      apb(1'b1, HST_CMD, 32'(C_PRINT));
      repeat (30) @(posedge clk);
      check(32'(n_stb - s0), 32'h0);
      printer_busy_in <= 1'b0;
      wait_idle();
      check(32'({n_stb - s0, printer_data}), 32'h15a);
      printer_online_in <= 1'b0;
      op(C_PRINT, 16'h0, 16'ha5);
      check(32'({n_stb - s0, q[1], printer_data}), 32'h35a);
      for (i = 0; i < 4; i++) begin
         barcode_wand <= i[0];
         cassette_read_in <= i[1];
         apb(1'b1, HST_SERIAL, 32'(i[1]));
         apb(1'b0, HST_STATUS, 32'h0);
         check(32'({q[3:2], cassette_write}), 32'({i[1], !i[0], !i[1]}));
      end
      summarize(0);
   end
endmodule : tb
`default_nettype wire
